// ### mrc_run_control.sv
// Operation
// - freeze query answers 1 while measurements are held, else 0.
// - integration 0 stops; 1 clears data, restarts, launches delay.
// - integration query codes: 0 idle, 1 delay, 2 held, 3 updating.
// - flag query returns all 32 bits and clears them at once.
// - each flag sets on its event and stays until cleared.
// - bits 0-2 non-harmonic done per analyzer; bit 3 motor done.
// - bits 8-10 harmonic done per analyzer; bit 16 spectrum done.
// - a committed configuration change clears all completion flags.
// - scope command: 0 stop, 1 single capture, 2 continuous capture.
// - starting a scope capture discards earlier captured view data.
// - scope query: 0/1 stopped, 2 single, 3/4 continuous, by data.
// - standby command stops or starts a run in the chosen analyzer.
// - standby query: 0 never run, 1 operator stop, 2 normal stop.
// - running standby: 3 wait level, 4 minimum, 5 extended, 6 second.
// - ten configuration stores each hold a full savable snapshot.
// - snapshots leave out power, interface and date format settings.
// - a factory store can be recalled but never overwritten.
// - save writes present configuration into store 1 to 10.
// - recall 0 loads factory, 1-10 a user store once saved.
// - freeze command 1 holds, 0 releases; freeze gives a running integration 2 after its delay.
`timescale 1ns/1ns
`include "mrc_cfg.svh"
module mrc_run_control
    import mrc_pkg::*;
#(
    parameter int             CFG_W       = `MRC_CFG_W,
    parameter logic [CFG_W-1:0] FACTORY_CFG = '0
)(
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             cmd_valid,
    input  wire mrc_cmd_s         cmd,
    output logic                  cmd_ready_r,
    output logic                  resp_valid_r,
    output mrc_resp_s             resp_r,
    input  wire mrc_evt_s         evt,
    input  wire logic             commit_configuration,
    input  wire logic             integration_state_query_delay_enabled,
    input  wire logic             integration_state_query_delay_expired,
    input  wire logic             scope_captured,
    input  wire mrc_stby_s        stby_evt,
    input  wire logic [CFG_W-1:0] cfg_savable,
    output logic                  measure_hold_r,
    output logic                  integration_state_query_clear_r,
    output logic                  integration_state_query_delay_start_r,
    output logic                  scope_clear_r,
    output mrc_scope_e            scope_mode_r,
    output logic [2:0]            stby_start_r,
    output logic [2:0]            stby_stop_r,
    output logic                  cfg_load_valid_r,
    output logic [CFG_W-1:0]      cfg_load_data_r
);
    initial
    begin
        if (CFG_W < 1)
            $error("mrc_run_control: CFG_W must be positive");
    end

    function automatic logic arg_ok(mrc_cmd_s c);
        logic ok;
        ok = 1'b1;
        case (c.code)
            MRC_CMD_FREEZE, MRC_CMD_INTEGRATION_STATE_QUERY: ok = c.arg <= `MRC_ARG_BOOL_MAX;
            MRC_CMD_SCOPE:  ok = c.arg <= `MRC_ARG_SCOPE_MAX;
            MRC_CMD_STBY:   ok = c.arg <= `MRC_ARG_BOOL_MAX &&
                                 c.analyzer != 2'h0;
            MRC_CMD_STBY_Q: ok = c.analyzer != 2'h0;
            MRC_CMD_SAVE:   ok = c.arg != 4'h0 && c.arg <= `MRC_STORE_MAX;
            MRC_CMD_RECALL: ok = c.arg <= `MRC_STORE_MAX;
            default:        ok = 1'b1;
        endcase
        return ok;
    endfunction

    function automatic logic stby_running(mrc_code_t s);
        return s >= `MRC_STBY_WAIT_LEVEL;
    endfunction

    logic                   take;
    logic                   good;
    logic [31:0]            evt_mask;
    logic                   flags_clr;
    logic [31:0]            flags_r, flags_nxt;
    logic                   integration_state_query_run_r, integration_state_query_run_nxt;
    logic                   integration_state_query_wait_r, integration_state_query_wait_nxt;
    mrc_code_t              integration_state_query_code;
    logic                   scope_data_r, scope_data_nxt;
    mrc_code_t              scope_code;
    mrc_code_t              stby_r [3];
    mrc_code_t              stby_nxt [3];
    logic [`MRC_STORES-1:0] saved_r, saved_nxt;
    logic                   pend_r, pend_nxt;
    logic                   pend_fac_r, pend_fac_nxt;
    logic                   mem_wr, mem_rd;
    logic [3:0]             store_idx;
    logic [CFG_W-1:0]       mem_rdata;
    logic                   cmd_ready_nxt, resp_valid_nxt, hold_nxt;
    mrc_resp_s              resp_nxt;
    logic                   iclr_nxt, idly_nxt, sclr_nxt, load_v_nxt;
    mrc_scope_e             scope_mode_nxt;
    logic [2:0]             start_nxt, stop_nxt;
    logic [CFG_W-1:0]       load_d_nxt;

    assign take      = cmd_valid && cmd_ready_r;
    assign good      = arg_ok(cmd);
    assign store_idx = cmd.arg - 4'h1;
    assign mem_wr    = take && good && cmd.code == MRC_CMD_SAVE;
    // Factory recall never indexes the user array
    assign mem_rd    = take && good && cmd.code == MRC_CMD_RECALL &&
                       cmd.arg != `MRC_RECALL_FACTORY;

    assign evt_mask  =
          (32'(evt.nonharm_done) << `MRC_FLAG_NONHARM_LSB)
        | (32'(evt.motor_done) << `MRC_FLAG_MOTOR)
        | (32'(evt.harm_done) << `MRC_FLAG_HARM_LSB)
        | (32'(evt.spectrum_done) << `MRC_FLAG_SPECTRUM);
    assign flags_clr = commit_configuration
                     || (take && cmd.code == MRC_CMD_FLAGS_Q);

    always_comb
    begin
        if (!integration_state_query_run_r)
            integration_state_query_code = `MRC_INTEGRATION_STATE_QUERY_IDLE;
        else if (integration_state_query_wait_r)
            integration_state_query_code = `MRC_INTEGRATION_STATE_QUERY_WAIT;
        else if (measure_hold_r)
            integration_state_query_code = `MRC_INTEGRATION_STATE_QUERY_HELD;
        else
            integration_state_query_code = `MRC_INTEGRATION_STATE_QUERY_RUN;
        case (scope_mode_r)
            MRC_SCOPE_ONCE:   scope_code = `MRC_SCOPE_SINGLE;
            MRC_SCOPE_REPEAT: scope_code = scope_data_r ?
                              `MRC_SCOPE_CONT_DATA : `MRC_SCOPE_CONT_EMPTY;
            default:          scope_code = scope_data_r ?
                              `MRC_SCOPE_STOP_DATA : `MRC_SCOPE_STOP_EMPTY;
        endcase
    end

    // Snapshot port carries savable settings only; excluded ones never enter
    mrc_store_mem #(
        .W     (CFG_W),
        .DEPTH (`MRC_STORES),
        .AW    (4)
    ) u_store (
        .clock     (clock),
        .wr_en     (mem_wr),
        .wr_idx    (store_idx),
        .wr_data   (cfg_savable),
        .rd_en     (mem_rd),
        .rd_idx    (store_idx),
        .rd_data_r (mem_rdata)
    );

    always_comb
    begin
        flags_nxt      = (flags_clr ? 32'h0 : flags_r) | evt_mask;
        integration_state_query_run_nxt  = integration_state_query_run_r;
        integration_state_query_wait_nxt = integration_state_query_wait_r && !integration_state_query_delay_expired;
        scope_data_nxt = scope_data_r;
        scope_mode_nxt = scope_mode_r;
        saved_nxt      = saved_r;
        hold_nxt       = measure_hold_r;
        pend_nxt       = 1'b0;
        pend_fac_nxt   = 1'b0;
        cmd_ready_nxt  = 1'b1;
        resp_valid_nxt = 1'b0;
        resp_nxt       = '0;
        iclr_nxt       = 1'b0;
        idly_nxt       = 1'b0;
        sclr_nxt       = 1'b0;
        start_nxt      = 3'h0;
        stop_nxt       = 3'h0;
        load_v_nxt     = 1'b0;
        load_d_nxt     = cfg_load_data_r;
        if (scope_captured && scope_mode_r != MRC_SCOPE_OFF)
        begin
            scope_data_nxt = 1'b1;
            if (scope_mode_r == MRC_SCOPE_ONCE)
                scope_mode_nxt = MRC_SCOPE_OFF;
        end
        for (int i = 0; i < `MRC_ANALYZERS; i++)
        begin
            stby_nxt[i] = stby_r[i];
            if (stby_evt.finished[i] && stby_running(stby_r[i]))
                stby_nxt[i] = `MRC_STBY_DONE;
            else if (stby_evt.level_seen[i] &&
                     stby_r[i] == `MRC_STBY_WAIT_LEVEL)
                stby_nxt[i] = `MRC_STBY_SECOND;
            else if (stby_evt.min_elapsed[i] &&
                     stby_r[i] == `MRC_STBY_MIN_PERIOD)
                stby_nxt[i] = `MRC_STBY_EXTENDED;
        end
        if (pend_r)
        begin
            load_v_nxt     = 1'b1;
            load_d_nxt     = pend_fac_r ? FACTORY_CFG : mem_rdata;
            resp_valid_nxt = 1'b1;
        end
        if (take)
        begin
            resp_valid_nxt = 1'b1;
            if (!good)
                resp_nxt.error = 1'b1;
            else
            begin
                case (cmd.code)
                    MRC_CMD_FREEZE:
                        hold_nxt = cmd.arg[0];
                    MRC_CMD_FREEZE_Q:
                        resp_nxt.data = 32'(measure_hold_r);
                    MRC_CMD_INTEGRATION_STATE_QUERY:
                    begin
                        integration_state_query_run_nxt  = cmd.arg[0];
                        integration_state_query_wait_nxt = cmd.arg[0] && integration_state_query_delay_enabled;
                        iclr_nxt       = cmd.arg[0];
                        idly_nxt       = cmd.arg[0] && integration_state_query_delay_enabled;
                    end
                    MRC_CMD_INTEGRATION_STATE_QUERY_Q:
                        resp_nxt.data = 32'(integration_state_query_code);
                    MRC_CMD_FLAGS_Q:
                        resp_nxt.data = flags_r;
                    MRC_CMD_SCOPE:
                    begin
                        scope_mode_nxt = mrc_scope_e'(cmd.arg[1:0]);
                        if (cmd.arg != 4'h0)
                        begin
                            // Old view is stale once a new capture begins
                            scope_data_nxt = 1'b0;
                            sclr_nxt       = 1'b1;
                        end
                    end
                    MRC_CMD_SCOPE_Q:
                        resp_nxt.data = 32'(scope_code);
                    MRC_CMD_STBY:
                    begin
                        if (cmd.arg[0])
                        begin
                            start_nxt[cmd.analyzer - 2'h1] = 1'b1;
                            stby_nxt[cmd.analyzer - 2'h1] =
                                stby_evt.second_method[cmd.analyzer - 2'h1]
                                ? `MRC_STBY_WAIT_LEVEL
                                : `MRC_STBY_MIN_PERIOD;
                        end
                        else if (stby_running(stby_r[cmd.analyzer - 2'h1]))
                        begin
                            stop_nxt[cmd.analyzer - 2'h1] = 1'b1;
                            // A run stopped before any data returns to 0
                            stby_nxt[cmd.analyzer - 2'h1] =
                                stby_r[cmd.analyzer - 2'h1] ==
                                `MRC_STBY_WAIT_LEVEL ? `MRC_STBY_NEVER
                                : `MRC_STBY_OP_STOP;
                        end
                    end
                    MRC_CMD_STBY_Q:
                        resp_nxt.data =
                            32'(stby_r[cmd.analyzer - 2'h1]);
                    MRC_CMD_SAVE:
                        saved_nxt[store_idx] = 1'b1;
                    MRC_CMD_RECALL:
                    begin
                        if (cmd.arg != `MRC_RECALL_FACTORY &&
                            !saved_r[store_idx])
                            resp_nxt.error = 1'b1;
                        else
                        begin
                            resp_valid_nxt = 1'b0;
                            pend_nxt       = 1'b1;
                            pend_fac_nxt   = cmd.arg == `MRC_RECALL_FACTORY;
                            cmd_ready_nxt  = 1'b0;
                        end
                    end
                    default:
                        resp_nxt.error = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            flags_r             <= `MRC_FLAGS_RESET;
            integration_state_query_run_r         <= 1'b0;
            integration_state_query_wait_r        <= 1'b0;
            scope_data_r        <= 1'b0;
            scope_mode_r        <= MRC_SCOPE_OFF;
            for (int i = 0; i < `MRC_ANALYZERS; i++)
                stby_r[i] <= `MRC_STBY_NEVER;
            saved_r             <= '0;
            pend_r              <= 1'b0;
            pend_fac_r          <= 1'b0;
            measure_hold_r      <= 1'b0;
            cmd_ready_r         <= 1'b1;
            resp_valid_r        <= 1'b0;
            resp_r              <= '0;
            integration_state_query_clear_r       <= 1'b0;
            integration_state_query_delay_start_r <= 1'b0;
            scope_clear_r       <= 1'b0;
            stby_start_r        <= 3'h0;
            stby_stop_r         <= 3'h0;
            cfg_load_valid_r    <= 1'b0;
            cfg_load_data_r     <= '0;
        end
        else
        begin
            flags_r             <= flags_nxt;
            integration_state_query_run_r         <= integration_state_query_run_nxt;
            integration_state_query_wait_r        <= integration_state_query_wait_nxt;
            scope_data_r        <= scope_data_nxt;
            scope_mode_r        <= scope_mode_nxt;
            stby_r              <= stby_nxt;
            saved_r             <= saved_nxt;
            pend_r              <= pend_nxt;
            pend_fac_r          <= pend_fac_nxt;
            measure_hold_r      <= hold_nxt;
            cmd_ready_r         <= cmd_ready_nxt;
            resp_valid_r        <= resp_valid_nxt;
            resp_r              <= resp_nxt;
            integration_state_query_clear_r       <= iclr_nxt;
            integration_state_query_delay_start_r <= idly_nxt;
            scope_clear_r       <= sclr_nxt;
            stby_start_r        <= start_nxt;
            stby_stop_r         <= stop_nxt;
            cfg_load_valid_r    <= load_v_nxt;
            cfg_load_data_r     <= load_d_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_freeze_q;
        take && cmd.code == MRC_CMD_FREEZE_Q |=>
            resp_valid_r && resp_r.data == 32'($past(measure_hold_r));
    endproperty
    a_freeze_q: assert property (p_freeze_q)
        else $error("freeze query answer wrong");

    property p_integration_state_query_start;
        take && good && cmd.code == MRC_CMD_INTEGRATION_STATE_QUERY && cmd.arg == 4'h1 |=>
            integration_state_query_clear_r && integration_state_query_code ==
            ($past(integration_state_query_delay_enabled) ? `MRC_INTEGRATION_STATE_QUERY_WAIT :
             measure_hold_r ? `MRC_INTEGRATION_STATE_QUERY_HELD : `MRC_INTEGRATION_STATE_QUERY_RUN);
    endproperty
    a_integration_state_query_start: assert property (p_integration_state_query_start)
        else $error("integration restart wrong");

    property p_flags_read;
        take && cmd.code == MRC_CMD_FLAGS_Q |=>
            resp_r.data == $past(flags_r) && flags_r == $past(evt_mask);
    endproperty
    a_flags_read: assert property (p_flags_read)
        else $error("flag read did not clear");

    property p_flags_sticky;
        !flags_clr ##1 !flags_clr |-> (flags_r & $past(flags_r)) ==
            $past(flags_r) && (flags_r & $past(evt_mask)) == $past(evt_mask);
    endproperty
    a_flags_sticky: assert property (p_flags_sticky)
        else $error("completion flag lost");

    property p_motor_bit;
        evt.motor_done |=> flags_r[`MRC_FLAG_MOTOR];
    endproperty
    a_motor_bit: assert property (p_motor_bit)
        else $error("motor flag not set");

    property p_spectrum_bit;
        evt.spectrum_done |=> flags_r[`MRC_FLAG_SPECTRUM];
    endproperty
    a_spectrum_bit: assert property (p_spectrum_bit)
        else $error("spectrum flag not set");

    property p_commit_clear;
        commit_configuration |=> flags_r == $past(evt_mask);
    endproperty
    a_commit_clear: assert property (p_commit_clear)
        else $error("commit did not clear flags");

    property p_scope_start;
        take && good && cmd.code == MRC_CMD_SCOPE && cmd.arg != 4'h0 |=>
            scope_clear_r && !scope_data_r &&
            scope_mode_r == mrc_scope_e'($past(cmd.arg[1:0])) && scope_code ==
            (scope_mode_r == MRC_SCOPE_ONCE ? `MRC_SCOPE_SINGLE
                                            : `MRC_SCOPE_CONT_EMPTY);
    endproperty
    a_scope_start: assert property (p_scope_start)
        else $error("scope start kept old data");

    property p_stby_start;
        take && good && cmd.code == MRC_CMD_STBY && cmd.arg == 4'h1 &&
            cmd.analyzer == 2'h1 |=> stby_start_r == 3'h1 &&
            stby_r[0] == ($past(stby_evt.second_method[0]) ?
            `MRC_STBY_WAIT_LEVEL : `MRC_STBY_MIN_PERIOD);
    endproperty
    a_stby_start: assert property (p_stby_start)
        else $error("standby start code wrong");

    property p_recall_unsaved;
        take && good && cmd.code == MRC_CMD_RECALL && cmd.arg != 4'h0 &&
            !saved_r[store_idx] |=> resp_r.error && !cfg_load_valid_r
            ##1 !cfg_load_valid_r;
    endproperty
    a_recall_unsaved: assert property (p_recall_unsaved)
        else $error("unsaved store recalled");

    property p_bad_arg;
        take && !good |=> resp_r.error && $stable(measure_hold_r) &&
            $stable(scope_mode_r) && $stable(integration_state_query_run_r) &&
            $stable(saved_r);
    endproperty
    a_bad_arg: assert property (p_bad_arg)
        else $error("refused command changed state");

    c_recall: cover property (take && cmd.code == MRC_CMD_RECALL ##2
                              cfg_load_valid_r);
    c_flags: cover property (take && cmd.code == MRC_CMD_FLAGS_Q &&
                             flags_r != 32'h0);
    c_stby_ext: cover property (stby_r[0] == `MRC_STBY_EXTENDED);
endmodule // mrc_run_control

// ### mrc_cfg.svh
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH

// Completion flag bit positions
`define MRC_FLAG_NONHARM_LSB 0
`define MRC_FLAG_MOTOR       3
`define MRC_FLAG_HARM_LSB    8
`define MRC_FLAG_SPECTRUM    16
`define MRC_FLAGS_RESET      32'h0000_0000

// Analyzers and stores
`define MRC_ANALYZERS        3
`define MRC_STORES           10
`define MRC_STORE_MAX        4'ha
`define MRC_RECALL_FACTORY   4'h0

// Argument limits
`define MRC_ARG_BOOL_MAX     4'h1
`define MRC_ARG_SCOPE_MAX    4'h2

// Integration state codes
`define MRC_INTEGRATION_STATE_QUERY_IDLE       3'h0
`define MRC_INTEGRATION_STATE_QUERY_WAIT       3'h1
`define MRC_INTEGRATION_STATE_QUERY_HELD       3'h2
`define MRC_INTEGRATION_STATE_QUERY_RUN        3'h3

// Scope view status codes
`define MRC_SCOPE_STOP_EMPTY 3'h0
`define MRC_SCOPE_STOP_DATA  3'h1
`define MRC_SCOPE_SINGLE     3'h2
`define MRC_SCOPE_CONT_EMPTY 3'h3
`define MRC_SCOPE_CONT_DATA  3'h4

// Standby state codes
`define MRC_STBY_NEVER       3'h0
`define MRC_STBY_OP_STOP     3'h1
`define MRC_STBY_DONE        3'h2
`define MRC_STBY_WAIT_LEVEL  3'h3
`define MRC_STBY_MIN_PERIOD  3'h4
`define MRC_STBY_EXTENDED    3'h5
`define MRC_STBY_SECOND      3'h6

// Default width of the savable configuration snapshot
`define MRC_CFG_W            64

`endif

// ### mrc_pkg.sv
package mrc_pkg;

    typedef enum logic [3:0] {
        MRC_CMD_FREEZE   = 4'h0,
        MRC_CMD_FREEZE_Q = 4'h1,
        MRC_CMD_INTEGRATION_STATE_QUERY    = 4'h2,
        MRC_CMD_INTEGRATION_STATE_QUERY_Q  = 4'h3,
        MRC_CMD_FLAGS_Q  = 4'h4,
        MRC_CMD_SCOPE    = 4'h5,
        MRC_CMD_SCOPE_Q  = 4'h6,
        MRC_CMD_STBY     = 4'h7,
        MRC_CMD_STBY_Q   = 4'h8,
        MRC_CMD_SAVE     = 4'h9,
        MRC_CMD_RECALL   = 4'ha
    } mrc_cmd_e;

    typedef enum logic [1:0] {
        MRC_SCOPE_OFF    = 2'h0,
        MRC_SCOPE_ONCE   = 2'h1,
        MRC_SCOPE_REPEAT = 2'h2
    } mrc_scope_e;

    typedef logic [2:0] mrc_code_t;

    typedef struct packed {
        mrc_cmd_e    code;
        logic [3:0]  arg;
        logic [1:0]  analyzer;
    } mrc_cmd_s;

    typedef struct packed {
        logic [31:0] data;
        logic        error;
    } mrc_resp_s;

    typedef struct packed {
        logic [2:0]  nonharm_done;
        logic        motor_done;
        logic [2:0]  harm_done;
        logic        spectrum_done;
    } mrc_evt_s;

    typedef struct packed {
        logic [2:0]  second_method;
        logic [2:0]  level_seen;
        logic [2:0]  min_elapsed;
        logic [2:0]  finished;
    } mrc_stby_s;

endpackage

// ### mrc_store_mem.sv
`timescale 1ns/1ns
module mrc_store_mem
    import mrc_pkg::*;
#(
    parameter int W     = 64,
    parameter int DEPTH = 10,
    parameter int AW    = 4
)(
    input  wire logic          clock,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_idx,
    output logic      [W-1:0]  rd_data_r
);
    initial
    begin
        if (DEPTH < 1 || DEPTH > (1 << AW) || W < 1)
            $error("mrc_store_mem: bad geometry");
    end

    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] rd_data_nxt;

    always_comb
    begin
        rd_data_nxt = rd_data_r;
        if (rd_en)
            rd_data_nxt = mem[rd_idx];
    end

    // No reset on contents; validity is tracked by the owner
    always_ff @(posedge clock)
    begin
        if (wr_en)
            mem[wr_idx] <= wr_data;
        rd_data_r <= rd_data_nxt;
    end
endmodule // mrc_store_mem

// ### mrc_host.sv
`timescale 1ns/1ns
module mrc_host
    import mrc_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      cmd_ready_r,
    input  wire logic      resp_valid_r,
    input  wire mrc_resp_s resp_r,
    output mrc_cmd_s       cmd,
    output logic           cmd_valid
);
    // Call just after a rising edge; the command holds until taken
    task automatic issue(input mrc_cmd_s c, output mrc_resp_s r);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd <= c;
        do
            @(posedge clock);
        while (cmd_ready_r !== 1'b1);
        cmd_valid <= 1'b0;
        // Released lines must not look like a fresh command
        cmd <= ~c;
        do
            @(posedge clock);
        while (resp_valid_r !== 1'b1 && n++ < 4);
        r = resp_r;
    endtask
    initial
    begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
endmodule // mrc_host

// ### measurement_run_control_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
n_mismatch++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module measurement_run_control_tb
    import mrc_pkg::*;
;
    logic        clock = 0, srst = 1, cmd_valid, commit = 0, den = 0;
    logic        dexp = 0, capt = 0, rdy, rv, hold, ld;
    mrc_cmd_s    cmd;
    mrc_resp_s   resp;
    mrc_evt_s    evt = '0;
    mrc_stby_s   sev = '0;
    logic [15:0] cfg = '0, ldd;
    logic [31:0] ef;
    logic        iclr, idly, sclr;
    logic [1:0]  smode;
    logic [2:0]  sst, ssp;
    int          n_mismatch = 0, comparisons = 0, cyc = 0, i;
    mrc_run_control #(.CFG_W(16), .FACTORY_CFG(16'h5a3c)) dut (
        .clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready_r(rdy), .resp_valid_r(rv), .resp_r(resp), .evt(evt),
        .commit_configuration(commit), .integration_state_query_delay_enabled(den),
        .integration_state_query_delay_expired(dexp), .scope_captured(capt),
        .stby_evt(sev), .cfg_savable(cfg), .measure_hold_r(hold),
        .integration_state_query_clear_r(iclr), .integration_state_query_delay_start_r(idly),
        .scope_clear_r(sclr), .scope_mode_r(smode),
        .stby_start_r(sst), .stby_stop_r(ssp),
        .cfg_load_valid_r(ld), .cfg_load_data_r(ldd));
    mrc_host u_host (.clock(clock), .cmd_ready_r(rdy), .resp_valid_r(rv),
        .resp_r(resp), .cmd(cmd), .cmd_valid(cmd_valid));
    task automatic q(mrc_cmd_e c, int a, int v, int e, int d);
        mrc_resp_s r;
        u_host.issue('{c, 4'(a), 2'(v)}, r);
        `CHK(r.error, 1'(e))
        `CHK(r.data, 32'(d))
    endtask
    task automatic tick;
        @(posedge clock);
        evt <= '0;
        sev <= {sev.second_method, 9'h0};
        {commit, dexp, capt} <= '0;
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial forever #2 clock = ~clock;
    // Whole run needs well under a thousand cycles
    always @(posedge clock)
        if (++cyc == 3000)
        begin
            n_mismatch++;
            summarize();
        end
    initial
    begin
        void'($urandom(57));
        repeat (12) @(posedge clock);
        srst <= 0;
        q(MRC_CMD_FREEZE, 1, 0, 0, 0);
        q(MRC_CMD_FREEZE_Q, 0, 0, 0, 1);
        `CHK(hold, 1'b1)
        q(MRC_CMD_INTEGRATION_STATE_QUERY, 1, 0, 0, 0);
        `CHK(iclr, 1'b1)
        `CHK(idly, 1'b0)
        q(MRC_CMD_INTEGRATION_STATE_QUERY_Q, 0, 0, 0, 2);
        q(MRC_CMD_FREEZE, 0, 0, 0, 0);
        q(MRC_CMD_FREEZE_Q, 0, 0, 0, 0);
        q(MRC_CMD_INTEGRATION_STATE_QUERY_Q, 0, 0, 0, 3);
        q(MRC_CMD_FREEZE, 2, 0, 1, 0);
        den <= 1;
        q(MRC_CMD_INTEGRATION_STATE_QUERY, 1, 0, 0, 0);
        `CHK(idly, 1'b1)
        q(MRC_CMD_INTEGRATION_STATE_QUERY_Q, 0, 0, 0, 1);
        dexp <= 1;
        tick();
        q(MRC_CMD_INTEGRATION_STATE_QUERY_Q, 0, 0, 0, 3);
        q(MRC_CMD_INTEGRATION_STATE_QUERY, 0, 0, 0, 0);
        q(MRC_CMD_INTEGRATION_STATE_QUERY_Q, 0, 0, 0, 0);
        $display("integration test done");
        ef = 0;
        for (i = 0; i < 3; i++)
        begin
            evt <= 8'($urandom);
            @(posedge clock);
            ef |= 32'({evt[0], 5'h0, evt[3:1], 4'h0, evt[4], evt[7:5]});
        end
        evt <= '0;
        q(MRC_CMD_FLAGS_Q, 0, 0, 0, ef);
        q(MRC_CMD_FLAGS_Q, 0, 0, 0, 0);
        evt <= 8'hff;
        @(posedge clock);
        // Motor event lands with the commit; set beats clear
        evt <= 8'h10;
        commit <= 1;
        tick();
        q(MRC_CMD_FLAGS_Q, 0, 0, 0, 32'h8);
        q(MRC_CMD_FLAGS_Q, 0, 0, 0, 0);
        q(MRC_CMD_SCOPE_Q, 0, 0, 0, 0);
        q(MRC_CMD_SCOPE, 2, 0, 0, 0);
        `CHK(smode, 2'h2)
        `CHK(sclr, 1'b1)
        q(MRC_CMD_SCOPE_Q, 0, 0, 0, 3);
        capt <= 1;
        tick();
        q(MRC_CMD_SCOPE_Q, 0, 0, 0, 4);
        q(MRC_CMD_SCOPE, 1, 0, 0, 0);
        q(MRC_CMD_SCOPE_Q, 0, 0, 0, 2);
        capt <= 1;
        tick();
        q(MRC_CMD_SCOPE_Q, 0, 0, 0, 1);
        q(MRC_CMD_SCOPE, 0, 0, 0, 0);
        q(MRC_CMD_SCOPE_Q, 0, 0, 0, 1);
        q(MRC_CMD_SCOPE, 3, 0, 1, 0);
        $display("flags and scope test done");
        q(MRC_CMD_STBY, 1, 2, 0, 0);
        `CHK(sst, 3'h2)
        q(MRC_CMD_STBY_Q, 0, 2, 0, 4);
        sev.min_elapsed <= 3'h2;
        tick();
        q(MRC_CMD_STBY_Q, 0, 2, 0, 5);
        sev.finished <= 3'h2;
        tick();
        q(MRC_CMD_STBY_Q, 0, 2, 0, 2);
        sev.second_method <= 3'h1;
        q(MRC_CMD_STBY, 1, 1, 0, 0);
        q(MRC_CMD_STBY_Q, 0, 1, 0, 3);
        sev.level_seen <= 3'h1;
        tick();
        q(MRC_CMD_STBY_Q, 0, 1, 0, 6);
        q(MRC_CMD_STBY, 0, 1, 0, 0);
        `CHK(ssp, 3'h1)
        q(MRC_CMD_STBY_Q, 0, 1, 0, 1);
        q(MRC_CMD_STBY, 1, 0, 1, 0);
        $display("standby test done");
        q(MRC_CMD_RECALL, 4, 0, 1, 0);
        ef = $urandom;
        cfg <= ef[15:0];
        q(MRC_CMD_SAVE, 4, 0, 0, 0);
        cfg <= ~ef[15:0];
        q(MRC_CMD_RECALL, 4, 0, 0, 0);
        `CHK(ld, 1'b1)
        `CHK(ldd, ef[15:0])
        q(MRC_CMD_RECALL, 0, 0, 0, 0);
        `CHK(ldd, 16'h5a3c)
        q(MRC_CMD_SAVE, 0, 0, 1, 0);
        q(MRC_CMD_SAVE, 11, 0, 1, 0);
        $display("store test done");
        srst <= 1;
        repeat (2) @(posedge clock);
        srst <= 0;
        q(MRC_CMD_RECALL, 4, 0, 1, 0);
        q(MRC_CMD_SCOPE_Q, 0, 0, 0, 0);
        q(MRC_CMD_STBY_Q, 0, 2, 0, 0);
        $display("reset test done");
        summarize();
    end
endmodule // measurement_run_control_tb
